// File: core/io_sampling_line_passing.sv
// Contract
// RULE_01: Pull enable bit one enables line pull
// RULE_02: Direction bit one pulls up, zero down
// RULE_03: Pulls only on digital-in or disabled lines
// RULE_04: No pull on sleep line during pin sleep
// RULE_05: Fixed bit map of pull lines
// RULE_06: Pull fields eight bits, reset all ones
// RULE_07: Forward remote samples framed when enabled
// RULE_08: Forwarding needs non-default source address
// RULE_09: Samples count 1..255, clipped to fit
// RULE_10: Transparent forced sample gives ASCII lines
// RULE_11: Framed forced sample: OK then data
// RULE_12: Eight-bit output level map for outputs
// RULE_13: Change mask triggers digital-only send
// RULE_14: Queued samples go before change send
// RULE_15: Nonzero interval samples every N ms
// RULE_16: Host avoids interval of 1 or 2
// RULE_17: RSSI PWM timer, 0xFF always on
// RULE_18: Remote digital drives same local line
// RULE_19: Analog channels 0,1 drive PWM 0,1
// RULE_20: All-ones disables, 0xFFFF accepts any
// RULE_21: Bound sample sets output and PWM lines
// RULE_22: Per-line hold timeout reverts outputs
// RULE_23: Peripheral pin selects, default enabled
// RULE_24: Framing modes raw, plain, escaped
// RULE_25: Prescaled ticks, counters clear on reset
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module io_sampling_line_passing #(
	parameter int LINES       = 8,
	parameter int MS_CYC      = io_line_pkg::MS_CYCLES,
	parameter int MAX_PAYLOAD = 100
) (
	// Clock and reset
	input  wire logic                     clock_in,
	input  wire logic                     srst_in,
	// Wishbone slave
	input  wire logic                     wb_cyc_in,
	input  wire logic                     wb_stb_in,
	input  wire logic                     wb_we_in,
	input  wire logic [7:0]               wb_adr_in,
	input  wire logic [3:0]               wb_sel_in,
	input  wire logic [31:0]              wb_dat_in,
	output logic      [31:0]              wb_dat_out,
	output logic                          wb_ack_out,
	// Pins and radio side
	input  wire logic [LINES-1:0]         line_pin_in,
	input  wire logic                     pin_sleep_in,
	input  wire io_line_pkg::rx_sample_t  rx_in,
	input  wire logic                     sample_busy_in,
	// Outputs
	output logic      [LINES-1:0]         line_out,
	output logic      [LINES-1:0]         line_oe_n_out,
	output logic      [7:0]               pull_en_out,
	output logic      [7:0]               pull_up_out,
	output logic      [9:0]               pulse_out_0,
	output logic      [9:0]               pulse_out_1,
	output logic                          rssi_pwm_on_out,
	output logic      [3:0]               pin_select_out,
	output logic      [1:0]               framing_mode_out,
	output io_line_pkg::sample_req_t      sample_req_out,
	output logic                          forward_out
);
	if (LINES != 8 || MS_CYC < 1 || MAX_PAYLOAD < 4)
		$error("Unsupported parameters");
	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers
	logic [7:0]  pull_enable_mask_q;
	logic [7:0]  pull_direction_mask_q;
	logic        sample_forward_enable_q;
	logic [7:0]  samples_per_tx_q;
	logic [15:0] change_detect_mask_q;
	logic [15:0] sample_interval_q;
	logic [7:0]  rssi_pwm_timer_q;
	logic [63:0] passing_source_addr_q;
	logic [7:0]  out_level_q;
	logic [23:0] line_cfg_q;
	logic [63:0] line_timeout_q;
	logic [3:0]  pin_sel_q;
	logic [1:0]  framing_mode_q;
	logic        force_pulse_q;
	logic [9:0]  duty0_q;
	logic [9:0]  duty1_q;
	logic        wr;
	logic        rd_hit;
	logic [7:0]  fit_max;
	logic [3:0]  enabled_cnt;
	assign wr = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out; // Lands as ack is sampled
	// Two bytes of digital data plus two per analog line among lines 0 to 3
	always_comb begin
		enabled_cnt = 4'h1;
		for (int i = 0; i < 4; i++)
			if (line_cfg_q[3*i +: 3] == io_line_pkg::FN_ANALOG)
				enabled_cnt = enabled_cnt + 4'h1;
		fit_max = 8'((MAX_PAYLOAD / 2) / int'(enabled_cnt));
	end
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			pull_enable_mask_q      <= io_line_pkg::PULL_RESET; // [RULE_06]
			pull_direction_mask_q   <= io_line_pkg::PULL_RESET; // [RULE_06]
			sample_forward_enable_q <= 1'b1;
			samples_per_tx_q        <= io_line_pkg::SAMPLES_RESET;
			change_detect_mask_q    <= io_line_pkg::CHANGE_RESET; // [RULE_13]
			sample_interval_q       <= io_line_pkg::INTERVAL_RESET; // [RULE_15]
			rssi_pwm_timer_q        <= io_line_pkg::RSSI_RESET; // [RULE_17]
			passing_source_addr_q   <= io_line_pkg::SRC_DISABLED;
			out_level_q             <= 8'h00;
			line_cfg_q              <= 24'h00_0000;
			line_timeout_q          <= {8{io_line_pkg::TIMEOUT_RESET}}; // [RULE_22]
			pin_sel_q               <= io_line_pkg::PIN_SEL_RESET; // [RULE_23]
			framing_mode_q          <= 2'h0;
			force_pulse_q           <= 1'b0;
			duty0_q                 <= 10'h000;
			duty1_q                 <= 10'h000;
		end else begin
			force_pulse_q <= 1'b0;
			if (wr && wb_sel_in[0]) begin
				case (wb_adr_in)
				io_line_pkg::ADDR_PULL_EN:     pull_enable_mask_q <= wb_dat_in[7:0];
				io_line_pkg::ADDR_PULL_DIR:    pull_direction_mask_q <= wb_dat_in[7:0];
				io_line_pkg::ADDR_CTRL: begin
					sample_forward_enable_q <= wb_dat_in[0];
					framing_mode_q <= (wb_dat_in[2:1] == 2'h3) ? 2'h0 : wb_dat_in[2:1]; // [RULE_24]
					force_pulse_q <= wb_dat_in[3];
					pin_sel_q <= wb_dat_in[7:4]; // [RULE_23]
				end
				io_line_pkg::ADDR_SAMPLES_TX: begin
					if (wb_dat_in[7:0] != 8'h00)
						samples_per_tx_q <= (wb_dat_in[7:0] > fit_max) ? fit_max
							: wb_dat_in[7:0]; // [RULE_09]
				end
				io_line_pkg::ADDR_CHANGE_MASK: change_detect_mask_q <= wb_dat_in[15:0];
				io_line_pkg::ADDR_INTERVAL:    sample_interval_q <= wb_dat_in[15:0];
				io_line_pkg::ADDR_RSSI_TIMER:  rssi_pwm_timer_q <= wb_dat_in[7:0];
				io_line_pkg::ADDR_SRC_LO:      passing_source_addr_q[31:0] <= wb_dat_in;
				io_line_pkg::ADDR_SRC_HI:      passing_source_addr_q[63:32] <= wb_dat_in;
				io_line_pkg::ADDR_OUT_LEVEL:   out_level_q <= wb_dat_in[7:0]; // [RULE_12]
				io_line_pkg::ADDR_LINE_CFG:    line_cfg_q <= wb_dat_in[23:0];
				io_line_pkg::ADDR_TIMEOUT_LO:  line_timeout_q[31:0] <= wb_dat_in;
				io_line_pkg::ADDR_TIMEOUT_HI:  line_timeout_q[63:32] <= wb_dat_in;
				io_line_pkg::ADDR_PWM_DUTY: begin
					duty0_q <= wb_dat_in[9:0];
					duty1_q <= wb_dat_in[25:16];
				end
				default: ;
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Timebase: 1 ms and 100 ms enables
	logic [31:0] pre_q;
	logic [7:0]  tenth_q;
	logic        ms_tick;
	logic        tenth_tick;
	assign ms_tick    = (pre_q == 32'(MS_CYC - 1));
	assign tenth_tick = ms_tick && (tenth_q == 8'(io_line_pkg::TENTH_PER_MS - 1));
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			pre_q   <= 32'h0000_0000; // [RULE_25]
			tenth_q <= 8'h00;
		end else begin
			pre_q <= ms_tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
			if (ms_tick)
				tenth_q <= tenth_tick ? 8'h00 : tenth_q + 8'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser, stages two and three must agree
	logic [LINES-1:0] sync1_q;
	logic [LINES-1:0] sync2_q;
	logic [LINES-1:0] sync3_q;
	logic [LINES-1:0] stable_q;
	logic             sleep1_q;
	logic             sleep2_q;
	logic             sleep3_q;
	logic             sleep_q;
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			sync1_q  <= 8'h00;
			sync2_q  <= 8'h00;
			sync3_q  <= 8'h00;
			stable_q <= 8'h00;
			sleep1_q <= 1'b0;
			sleep2_q <= 1'b0;
			sleep3_q <= 1'b0;
			sleep_q  <= 1'b0;
		end else begin
			sync1_q  <= line_pin_in;
			sync2_q  <= sync1_q;
			sync3_q  <= sync2_q;
			stable_q <= (stable_q & (sync2_q ^ sync3_q)) | (sync2_q & sync3_q);
			sleep1_q <= pin_sleep_in;
			sleep2_q <= sleep1_q;
			sleep3_q <= sleep2_q;
			if (sleep2_q == sleep3_q)
				sleep_q <= sleep2_q;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Pull resistor control
	// Pull bit n maps to line: 4,3,2,1,0,6,sleep,data-in [RULE_05]
	logic [7:0] pull_ok;
	always_comb begin
		pull_ok = 8'hFF;
		pull_ok[0] = fn_allows(line_cfg_q[12 +: 3]);
		pull_ok[1] = fn_allows(line_cfg_q[9 +: 3]);
		pull_ok[2] = fn_allows(line_cfg_q[6 +: 3]);
		pull_ok[3] = fn_allows(line_cfg_q[3 +: 3]);
		pull_ok[4] = fn_allows(line_cfg_q[0 +: 3]);
		pull_ok[5] = fn_allows(line_cfg_q[18 +: 3]);
		pull_ok[6] = !sleep_q; // [RULE_04]
	end
	function automatic logic fn_allows(input logic [2:0] f);
		return (f == 3'h0) || (f == 3'h3); // [RULE_03]
	endfunction
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			pull_en_out <= 8'h00;
			pull_up_out <= 8'h00;
		end else begin
			pull_en_out <= pull_enable_mask_q & pull_ok; // [RULE_01]
			pull_up_out <= pull_direction_mask_q & pull_enable_mask_q & pull_ok; // [RULE_02]
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Line passing and hold timeouts
	logic        src_ok;
	logic        bound;
	logic [7:0]  passed_q;
	logic [7:0]  held_q;
	logic [7:0]  hold_cnt_q [LINES];
	logic [7:0]  is_out;
	logic [7:0]  cfg_level;
	// Source filter [RULE_20]
	assign src_ok = (passing_source_addr_q != io_line_pkg::SRC_DISABLED) && rx_in.to_me
		&& ((passing_source_addr_q == io_line_pkg::SRC_ANY)
		|| (rx_in.src == passing_source_addr_q));
	assign bound = rx_in.valid && src_ok;
	// Codes four and up drive the line
	always_comb begin
		for (int i = 0; i < LINES; i++) begin
			is_out[i]    = (line_cfg_q[3*i +: 3] >= 3'h4);
			cfg_level[i] = (line_cfg_q[3*i +: 3] == 3'h5) ^ out_level_q[i];
		end
	end
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			passed_q <= 8'h00;
			held_q   <= 8'h00;
			for (int i = 0; i < LINES; i++)
				hold_cnt_q[i] <= 8'h00; // [RULE_25]
		end else begin
			for (int i = 0; i < LINES; i++) begin
				if (bound && is_out[i]) begin
					passed_q[i]   <= rx_in.dig[i]; // [RULE_18] [RULE_21]
					held_q[i]     <= 1'b1;
					hold_cnt_q[i] <= line_timeout_q[8*i +: 8];
				end else if (held_q[i] && tenth_tick && line_timeout_q[8*i +: 8] != 8'h00) begin
					// Zero timeout leaves the passed value in place
					if (hold_cnt_q[i] <= 8'h01)
						held_q[i] <= 1'b0; // [RULE_22]
					hold_cnt_q[i] <= hold_cnt_q[i] - 8'h01;
				end
			end
		end
	end
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			line_out      <= 8'h00;
			line_oe_n_out <= 8'hFF;
		end else begin
			line_out      <= held_q & passed_q | ~held_q & cfg_level;
			line_oe_n_out <= ~is_out;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// PWM duty and RSSI timer
	logic [7:0] rssi_cnt_q;
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			pulse_out_0     <= 10'h000;
			pulse_out_1     <= 10'h000;
			rssi_cnt_q      <= 8'h00;
			rssi_pwm_on_out <= 1'b0;
		end else begin
			pulse_out_0 <= bound ? rx_in.an0 : pulse_out_0; // [RULE_19]
			pulse_out_1 <= bound ? rx_in.an1 : pulse_out_1; // [RULE_19]
			if (wr && wb_sel_in[0] && wb_adr_in == io_line_pkg::ADDR_PWM_DUTY) begin
				pulse_out_0 <= wb_dat_in[9:0];
				pulse_out_1 <= wb_dat_in[25:16];
			end
			if (rx_in.valid) begin
				rssi_cnt_q      <= rssi_pwm_timer_q; // [RULE_17]
				rssi_pwm_on_out <= rssi_pwm_timer_q != 8'h00;
			end else if (tenth_tick && rssi_cnt_q != 8'h00
				&& rssi_pwm_timer_q != io_line_pkg::TIMER_FOREVER) begin // [RULE_17]
				rssi_cnt_q <= rssi_cnt_q - 8'h01;
				if (rssi_cnt_q == 8'h01)
					rssi_pwm_on_out <= 1'b0; // [RULE_17]
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Sample triggers: forced, periodic, change
	logic [15:0] ival_cnt_q;
	logic [7:0]  prev_q;
	logic        change_hit;
	logic        periodic_hit;
	logic        pend_q;
	assign change_hit   = |((stable_q ^ prev_q) & change_detect_mask_q[7:0]); // [RULE_13]
	assign periodic_hit = ms_tick && sample_interval_q != 16'h0000
		&& ival_cnt_q + 16'h0001 >= sample_interval_q; // [RULE_15]
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			ival_cnt_q     <= 16'h0000;
			prev_q         <= 8'h00;
			pend_q         <= 1'b0;
			sample_req_out <= '0;
		end else begin
			prev_q <= stable_q;
			if (sample_interval_q == 16'h0000 || periodic_hit)
				ival_cnt_q <= 16'h0000;
			else if (ms_tick)
				ival_cnt_q <= ival_cnt_q + 16'h0001;
			// Held while busy; a change then waits its turn
			if (!sample_busy_in)
				sample_req_out <= '0;
			if (!sample_busy_in && (force_pulse_q || pend_q || change_hit || periodic_hit)) begin
				sample_req_out.valid        <= 1'b1;
				sample_req_out.forced       <= force_pulse_q;
				sample_req_out.ascii        <= force_pulse_q
					&& framing_mode_q == io_line_pkg::FRAME_RAW; // [RULE_10]
				sample_req_out.ok_first     <= force_pulse_q
					&& framing_mode_q != io_line_pkg::FRAME_RAW; // [RULE_11]
				sample_req_out.digital_only <= (change_hit || pend_q) && !force_pulse_q;
				sample_req_out.flush_first  <= change_hit || pend_q; // [RULE_14]
				pend_q <= 1'b0;
			end else if (change_hit) begin
				pend_q <= 1'b1;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Forwarding and fixed outputs
	always_ff @(posedge clock_in) begin
		if (srst_in)
			forward_out <= 1'b0;
		else
			forward_out <= rx_in.valid && sample_forward_enable_q // [RULE_07]
				&& passing_source_addr_q != io_line_pkg::SRC_DISABLED; // [RULE_08]
	end
	assign pin_select_out   = pin_sel_q;
	assign framing_mode_out = framing_mode_q;
	////////////////////////////////////////////////////////////////////////////////
	// Read path; one wait state, unmapped reads return zero
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end else begin
			wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
			case (wb_adr_in)
			io_line_pkg::ADDR_PULL_EN:     wb_dat_out <= {24'h00_0000, pull_enable_mask_q};
			io_line_pkg::ADDR_PULL_DIR:    wb_dat_out <= {24'h00_0000, pull_direction_mask_q};
			io_line_pkg::ADDR_CTRL:        wb_dat_out <= {24'h00_0000, pin_sel_q, 1'b0,
				framing_mode_q, sample_forward_enable_q};
			io_line_pkg::ADDR_SAMPLES_TX:  wb_dat_out <= {24'h00_0000, samples_per_tx_q};
			io_line_pkg::ADDR_CHANGE_MASK: wb_dat_out <= {16'h0000, change_detect_mask_q};
			io_line_pkg::ADDR_INTERVAL:    wb_dat_out <= {16'h0000, sample_interval_q};
			io_line_pkg::ADDR_RSSI_TIMER:  wb_dat_out <= {24'h00_0000, rssi_pwm_timer_q};
			io_line_pkg::ADDR_SRC_LO:      wb_dat_out <= passing_source_addr_q[31:0];
			io_line_pkg::ADDR_SRC_HI:      wb_dat_out <= passing_source_addr_q[63:32];
			io_line_pkg::ADDR_OUT_LEVEL:   wb_dat_out <= {24'h00_0000, out_level_q};
			io_line_pkg::ADDR_LINE_CFG:    wb_dat_out <= {8'h00, line_cfg_q};
			io_line_pkg::ADDR_TIMEOUT_LO:  wb_dat_out <= line_timeout_q[31:0];
			io_line_pkg::ADDR_TIMEOUT_HI:  wb_dat_out <= line_timeout_q[63:32];
			io_line_pkg::ADDR_STATUS:      wb_dat_out <= {16'h0000, held_q, stable_q};
			io_line_pkg::ADDR_PWM_DUTY:    wb_dat_out <= {6'h00, duty1_q, 6'h00, duty0_q};
			default:                       wb_dat_out <= 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

// File: inc/io_line_pkg.sv
package io_line_pkg;
	// Register byte offsets on the Wishbone slave
	localparam logic [7:0] ADDR_PULL_EN     = 8'h00;
	localparam logic [7:0] ADDR_PULL_DIR    = 8'h04;
	localparam logic [7:0] ADDR_CTRL        = 8'h08;
	localparam logic [7:0] ADDR_SAMPLES_TX  = 8'h0C;
	localparam logic [7:0] ADDR_CHANGE_MASK = 8'h10;
	localparam logic [7:0] ADDR_INTERVAL    = 8'h14;
	localparam logic [7:0] ADDR_RSSI_TIMER  = 8'h18;
	localparam logic [7:0] ADDR_SRC_LO      = 8'h1C;
	localparam logic [7:0] ADDR_SRC_HI      = 8'h20;
	localparam logic [7:0] ADDR_OUT_LEVEL   = 8'h24;
	localparam logic [7:0] ADDR_LINE_CFG    = 8'h28;
	localparam logic [7:0] ADDR_TIMEOUT_LO  = 8'h2C;
	localparam logic [7:0] ADDR_TIMEOUT_HI  = 8'h30;
	localparam logic [7:0] ADDR_STATUS      = 8'h34;
	localparam logic [7:0] ADDR_PWM_DUTY    = 8'h38;
	// Reset values and special codes
	localparam logic [7:0]  PULL_RESET       = 8'hFF;
	localparam logic [7:0]  SAMPLES_RESET    = 8'h01;
	localparam logic [15:0] CHANGE_RESET     = 16'h0000;
	localparam logic [15:0] INTERVAL_RESET   = 16'h0000;
	localparam logic [7:0]  RSSI_RESET       = 8'h28;
	localparam logic [7:0]  TIMEOUT_RESET    = 8'hFF;
	localparam logic [7:0]  TIMER_FOREVER    = 8'hFF;
	localparam logic [63:0] SRC_DISABLED     = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic [63:0] SRC_ANY          = 64'h0000_0000_0000_FFFF;
	localparam logic [3:0]  PIN_SEL_RESET    = 4'hF;
	// Timing
	localparam int CLK_HZ        = 100_000_000;
	localparam int MS_TICK_MS    = 1;
	localparam int MS_CYCLES     = CLK_HZ / 1000 * MS_TICK_MS;
	localparam int TENTH_MS      = 100;
	localparam int TENTH_PER_MS  = TENTH_MS / MS_TICK_MS;
	// Line functions, one 3-bit code per line
	typedef enum logic [2:0] {
		FN_DISABLED = 3'h0,
		FN_PERIPH   = 3'h1,
		FN_ANALOG   = 3'h2,
		FN_DIG_IN   = 3'h3,
		FN_OUT_LOW  = 3'h4,
		FN_OUT_HIGH = 3'h5
	} line_fn_t;
	typedef enum logic [1:0] {
		FRAME_RAW     = 2'h0,
		FRAME_PLAIN   = 2'h1,
		FRAME_ESCAPED = 2'h2
	} framing_mode_t;
	// Received remote sample
	typedef struct packed {
		logic        valid;
		logic [63:0] src;
		logic        to_me;
		logic [7:0]  dig;
		logic [9:0]  an0;
		logic [9:0]  an1;
	} rx_sample_t;
	// Sample request toward the sampler/framer
	typedef struct packed {
		logic       valid;
		logic       digital_only;
		logic       flush_first;
		logic       forced;
		logic       ascii;
		logic       ok_first;
	} sample_req_t;
endpackage

// File: bench/io_line_props.sv
`timescale 1ns/1ps
`default_nettype none
module io_line_props #(
	parameter int LINES = 8
) (
	// Clock, reset and bus
	input wire logic                     clock_in,
	input wire logic                     srst_in,
	input wire logic                     wb_cyc_in,
	input wire logic                     wb_stb_in,
	input wire logic                     wb_ack_out,
	// Pins, radio and outputs
	input wire logic                     pin_sleep_in,
	input wire io_line_pkg::rx_sample_t  rx_in,
	input wire logic                     sample_busy_in,
	input wire logic [LINES-1:0]         line_oe_n_out,
	input wire logic [7:0]               pull_en_out,
	input wire logic [1:0]               framing_mode_out,
	input wire io_line_pkg::sample_req_t sample_req_out,
	input wire logic                     forward_out
);
	logic [1:0] rx_age_q;
	////////////////////////////////////////////////////////////
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			rx_age_q <= 2'h3;
		end else if (rx_in.valid) begin
			rx_age_q <= 2'h0;
		end else if (rx_age_q != 2'h3) begin
			rx_age_q <= rx_age_q + 2'h1;
		end
	end
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (srst_in);
	sequence bus_req;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	sequence ack_pulse;
		wb_ack_out ##1 !wb_ack_out;
	endsequence
	chk_ack_one_wait: assert property (bus_req |=> ack_pulse)
		else $error("ack missing or too long");
	chk_ack_has_cause: assert property ($rose(wb_ack_out) |-> $past(wb_stb_in) && $past(wb_cyc_in))
		else $error("ack without request");
	// Sync chain delay is below six cycles
	chk_sleep_no_pull: assert property (pin_sleep_in [*6] |-> !pull_en_out[6])
		else $error("pull on sleep line in pin sleep");
	chk_out0_no_pull: assert property (!line_oe_n_out[0] [*2] |-> !pull_en_out[4])
		else $error("pull on driven line 0");
	chk_out4_no_pull: assert property (!line_oe_n_out[4] [*2] |-> !pull_en_out[0])
		else $error("pull on driven line 4");
	chk_fwd_cause: assert property (forward_out |-> rx_age_q <= 2'h2)
		else $error("forward without received sample");
	chk_req_held: assert property (sample_req_out.valid && sample_busy_in |=> $stable(sample_req_out))
		else $error("request changed while busy");
	chk_frame_legal: assert property (framing_mode_out != 2'h3)
		else $error("illegal framing mode");
	chk_change_flush: assert property (sample_req_out.valid && sample_req_out.digital_only
		|-> sample_req_out.flush_first) else $error("change sample without flush");
	chk_force_format: assert property (sample_req_out.valid && sample_req_out.forced
		|-> (sample_req_out.ascii == (framing_mode_out == 2'h0))
		&& (sample_req_out.ok_first != sample_req_out.ascii)) else $error("forced sample format");
endmodule
bind io_sampling_line_passing io_line_props #(.LINES(LINES)) io_line_props_i (
	.clock_in(clock_in), .srst_in(srst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
	.wb_ack_out(wb_ack_out), .pin_sleep_in(pin_sleep_in), .rx_in(rx_in),
	.sample_busy_in(sample_busy_in), .line_oe_n_out(line_oe_n_out), .pull_en_out(pull_en_out),
	.framing_mode_out(framing_mode_out), .sample_req_out(sample_req_out),
	.forward_out(forward_out));
`default_nettype wire

// File: bench/remote_node_model.sv
`timescale 1ns/1ps
`default_nettype none
module remote_node_model #(
	parameter int BUSY_CYC = 4
) (
	// Clock and reset
	input  wire logic                     clock_in,
	input  wire logic                     srst_in,
	// Bench and block requests
	input  wire logic                     send_in,
	input  wire io_line_pkg::rx_sample_t  pkt_in,
	input  wire io_line_pkg::sample_req_t req_in,
	// Toward the block
	output io_line_pkg::rx_sample_t       rx_out,
	output logic                          busy_out
);
	logic [7:0] busy_q;
	////////////////////////////////////////////////////////////
	// Fields flip between packets so stale data never passes as fresh
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			rx_out <= '0;
		end else if (send_in) begin
			rx_out <= pkt_in;
		end else begin
			rx_out <= {1'b0, ~rx_out[$bits(rx_out)-2:0]};
		end
	end
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			busy_q <= 8'h00;
		end else if (busy_q != 8'h00) begin
			busy_q <= busy_q - 8'h01;
		end else if (req_in.valid) begin
			busy_q <= BUSY_CYC[7:0];
		end
	end
	assign busy_out = (busy_q != 8'h00);
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int PAY = 100;
	logic                     clock_in, srst_in, cyc, stb, we, send, sleep, busy, fwd, rssi, ack;
	logic [3:0]               sel, psel;
	logic [7:0]               adr, pins, lo, oe_n, pen, pup;
	logic [31:0]              wd, rd, dat;
	logic [9:0]               p0, p1;
	logic [1:0]               fmode;
	io_line_pkg::rx_sample_t  rx, pkt;
	io_line_pkg::sample_req_t req, last;
	int                       err_total, n_checks, n_req, n_fwd, k;
	////////////////////////////////////////////////////////////
	// Short ms prescaler keeps timeout runs brief
	io_sampling_line_passing #(.MS_CYC(10), .MAX_PAYLOAD(PAY)) io_sampling_line_passing_i (
		.clock_in(clock_in), .srst_in(srst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(dat),
		.wb_ack_out(ack), .line_pin_in(pins), .pin_sleep_in(sleep), .rx_in(rx),
		.sample_busy_in(busy), .line_out(lo), .line_oe_n_out(oe_n), .pull_en_out(pen),
		.pull_up_out(pup), .pulse_out_0(p0), .pulse_out_1(p1), .rssi_pwm_on_out(rssi),
		.pin_select_out(psel), .framing_mode_out(fmode), .sample_req_out(req),
		.forward_out(fwd));
	remote_node_model #(.BUSY_CYC(4)) remote_node_model_i (.clock_in(clock_in),
		.srst_in(srst_in), .send_in(send), .pkt_in(pkt), .req_in(req), .rx_out(rx),
		.busy_out(busy));
	////////////////////////////////////////////////////////////
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	always @(negedge clock_in) begin
		if (req.valid === 1'b1 && busy === 1'b0) begin
			n_req++;
			last = req;
		end
		if (fwd === 1'b1) n_fwd++;
	end
	////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		k = 0;
		@(posedge clock_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clock_in);
			k++;
		end while (ack !== 1'b1 && k < 20);
		check(32'(ack), 32'h0000_0001);
		rd = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		check(rd, e);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clock_in);
		@(negedge clock_in);
	endtask
	task automatic rx_send(input logic [63:0] s, input logic [7:0] dg);
		@(posedge clock_in);
		pkt <= '{1'b1, s, 1'b1, dg, 10'h2A5, 10'h15A};
		send <= 1'b1;
		@(posedge clock_in);
		send <= 1'b0;
		settle(8);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		{cyc, stb, we, send, sleep} = 5'h00;
		sel = 4'hF;
		adr = 8'h00;
		wd = 32'h0000_0000;
		pins = 8'h00;
		pkt = '0;
		srst_in = 1'b1;
		{err_total, n_checks, n_req, n_fwd} = '0;
		repeat (8) @(posedge clock_in);
		srst_in <= 1'b0;
		rdc(8'h00, 32'h0000_00FF);
		rdc(8'h04, 32'h0000_00FF);
		rdc(8'h08, 32'h0000_00F1);
		rdc(8'h0C, 32'h0000_0001);
		rdc(8'h10, 32'h0000_0000);
		rdc(8'h14, 32'h0000_0000);
		rdc(8'h18, 32'h0000_0028);
		rdc(8'h1C, 32'hFFFF_FFFF);
		rdc(8'h2C, 32'hFFFF_FFFF);
		rdc(8'h3C, 32'h0000_0000);
		settle(2);
		check(32'({pen, pup, psel}), 32'h000F_FFFF);
		$display("reset test done");
		wb(1'b1, 8'h00, 32'h0000_006F);
		wb(1'b1, 8'h04, 32'h0000_000F);
		wb(1'b1, 8'h28, 32'h0000_401D);
		settle(4);
		check(32'({pen, pup & pen}), 32'h0000_6E0E);
		check(32'({oe_n, lo & ~oe_n}), 32'h0000_EE01);
		wb(1'b1, 8'h24, 32'h0000_0011);
		settle(2);
		check(32'(lo & ~oe_n), 32'h0000_0010);
		wb(1'b1, 8'h24, 32'h0000_0000);
		sleep <= 1'b1;
		settle(8);
		check(32'(pen[6]), 32'h0000_0000);
		@(posedge clock_in);
		sleep <= 1'b0;
		$display("pull test done");
		wb(1'b1, 8'h0C, 32'h0000_00FF);
		rdc(8'h0C, 32'(PAY / 2));
		wb(1'b1, 8'h0C, 32'h0000_0000);
		rdc(8'h0C, 32'(PAY / 2));
		$display("count test done");
		wb(1'b1, 8'h2C, 32'h0000_0001);
		wb(1'b1, 8'h30, 32'h0000_0000);
		wb(1'b1, 8'h1C, 32'h0000_1234);
		wb(1'b1, 8'h20, 32'h0000_0000);
		rx_send(64'h0000_0000_0000_1234, 8'h00);
		check(32'(lo & ~oe_n), 32'h0000_0000);
		check({6'h00, p1, 6'h00, p0}, 32'h015A_02A5);
		check(n_fwd, 32'h0000_0001);
		rx_send(64'h0000_0000_0000_0055, 8'hFF);
		check(32'(lo & ~oe_n), 32'h0000_0000);
		settle(2100);
		check(32'(lo & ~oe_n), 32'h0000_0001);
		wb(1'b1, 8'h1C, 32'h0000_FFFF);
		rx_send(64'h0000_0000_0000_9999, 8'hFF);
		check(32'(lo & ~oe_n), 32'h0000_0011);
		wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
		wb(1'b1, 8'h20, 32'hFFFF_FFFF);
		n_fwd = 0;
		rx_send(64'h0000_0000_0000_9999, 8'h00);
		check(32'(lo & ~oe_n), 32'h0000_0011);
		check(n_fwd, 32'h0000_0000);
		$display("passing test done");
		wb(1'b1, 8'h18, 32'h0000_0001);
		rx_send(64'h0000_0000_0000_9999, 8'h00);
		check(32'(rssi), 32'h0000_0001);
		settle(2100);
		check(32'(rssi), 32'h0000_0000);
		wb(1'b1, 8'h18, 32'h0000_00FF);
		rx_send(64'h0000_0000_0000_9999, 8'h00);
		settle(2100);
		check(32'(rssi), 32'h0000_0001);
		$display("rssi test done");
		// Interval kept above two so the sampler can keep pace
		wb(1'b1, 8'h14, 32'h0000_0003);
		n_req = 0;
		settle(300);
		check(32'(n_req >= 5), 32'h0000_0001);
		wb(1'b1, 8'h14, 32'h0000_0000);
		settle(20);
		n_req = 0;
		settle(300);
		check(n_req, 32'h0000_0000);
		wb(1'b1, 8'h10, 32'h0000_0002);
		pins <= 8'h02;
		settle(20);
		check(32'({last.digital_only, last.flush_first}), 32'h0000_0003);
		$display("sampling test done");
		wb(1'b1, 8'h08, 32'h0000_00F9);
		settle(10);
		check(32'({last.forced, last.ascii, last.ok_first}), 32'h0000_0006);
		wb(1'b1, 8'h08, 32'h0000_00FB);
		settle(10);
		check(32'({last.forced, last.ascii, last.ok_first}), 32'h0000_0005);
		check(32'(fmode), 32'h0000_0001);
		wb(1'b1, 8'h08, 32'h0000_0055);
		settle(2);
		check(32'({fmode, psel}), 32'h0000_0025);
		$display("force test done");
		print_verdict();
	end
	initial begin
		repeat (40000) @(posedge clock_in);
		err_total++;
		print_verdict();
	end
endmodule
`default_nettype wire
